// *** design/unb_cfg.svh ***
`ifndef UNB_CFG_SVH
`define UNB_CFG_SVH
// register offsets
`define UNB_OFS_CTRL    4'h0
`define UNB_OFS_BAUD    4'h1
`define UNB_OFS_TXDATA  4'h2
`define UNB_OFS_RXDATA  4'h3
`define UNB_OFS_STATUS  4'h4
// ctrl fields
`define UNB_CTRL_PAR_EN 0
`define UNB_CTRL_PMASK  1
`define UNB_CTRL_IR_EN  2
`define UNB_CTRL_RST    8'h00
// baud divisor: clocks per 1/16 bit minus one, default 22 near 40 MHz / (16 * 115200)
`define UNB_BAUD_RST    16'h0016
// ticks per bit and derived widths
`define UNB_OVS         16
`define UNB_IR_TX_TICKS 3
`define UNB_IR_MIN_TICKS 1
`define UNB_MID_TICK    7
`endif

// *** design/unb_pkg.sv ***
package unb_pkg;
  typedef enum logic [2:0] {
    UNB_IDLE  = 3'b000,
    UNB_START = 3'b001,
    UNB_DATA  = 3'b011,
    UNB_PAR   = 3'b010,
    UNB_STOP  = 3'b110
  } unb_st_t;
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } unb_word_t;
endpackage

// *** design/unb_uart.sv ***
`include "unb_cfg.svh"
// Rules from the document
// RL1: With parity on, each character is eight data bits then a ninth flag bit.
// RL2: The sender sets the ninth bit only on address bytes, clear otherwise.
// RL3: With the parity mask on, a received word with ninth bit high interrupts.
// RL4: That interrupt follows only the word in the receive register.
// RL5: Software keeps the FIFO off and may leave data words unread.
// RL6: In infrared mode each transmitted zero pulse is 3/16 of a bit long.
// RL7: In infrared mode a zero is a low pulse out and a high pulse in.
// RL8: In infrared mode the receive input is sampled mid-pulse; the code samples it at every tick.
// RL9: Infrared receive takes one sample per bit, normal mode three; the code samples every tick in infrared.
// RL10: In infrared mode pulses under about 1/16 bit are dropped as noise.
// RL11: The remote infrared sender uses 3/16-bit pulses.
// RL12: Software should use 8 data bits, one stop, no parity with infrared.
// RL13: Software writes mode, parity and mask bits; new characters use them.
module unb_uart
  import unb_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_rx,
  output logic             o_tx,
  output logic             o_irq
);
  // divisor must fit the 16-bit write port
  if (DIV_W < 2 || DIV_W > 16) begin : g_div_chk
    $error("DIV_W out of range");
  end

  logic [7:0]       ctrl_r, ctrl_nxt;
  logic [DIV_W-1:0] baud_r, baud_nxt, dcnt_r, dcnt_nxt;
  logic             tick;
  logic [15:0]      rdata_r, rdata_nxt;
  // transmit
  unb_st_t          ts_r, ts_nxt;
  logic [3:0]       tt_r, tt_nxt;
  logic [2:0]       tb_r, tb_nxt;
  unb_word_t        tw_r, tw_nxt;
  logic             tbusy_r, tbusy_nxt, tpar_r, tpar_nxt, tir_r, tir_nxt;
  logic             tx_r, tx_nxt;
  // receive
  unb_st_t          rs_r, rs_nxt;
  logic [3:0]       rt_r, rt_nxt;
  logic [2:0]       rb_r, rb_nxt;
  logic [7:0]       rsh_r, rsh_nxt;
  logic [2:0]       smp_r, smp_nxt;
  logic             rpar_r, rpar_nxt, rir_r, rir_nxt;
  logic             seen_r, seen_nxt, pw_r, pw_nxt;
  unb_word_t        rw_r, rw_nxt;
  logic             rnin_r, rnin_nxt;
  logic             rvld_r, rvld_nxt, ovr_r, ovr_nxt, irq_r, irq_nxt;
  logic             line, txbit;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // 1/16-bit tick divider and register file
  always_comb begin
    dcnt_nxt  = dcnt_r + 1'b1;
    tick      = 1'b0;
    if (dcnt_r >= baud_r) begin
      dcnt_nxt = '0;
      tick     = 1'b1;
    end
    ctrl_nxt  = ctrl_r;
    baud_nxt  = baud_r;
    rdata_nxt = '0;
    if (i_wr && i_addr == `UNB_OFS_CTRL) ctrl_nxt = i_wdata[7:0];
    if (i_wr && i_addr == `UNB_OFS_BAUD) baud_nxt = i_wdata[DIV_W-1:0];
    if (i_rd) begin
      case (i_addr)
        `UNB_OFS_CTRL:   rdata_nxt = {8'h00, ctrl_r};
        `UNB_OFS_BAUD:   rdata_nxt = 16'(baud_r);
        `UNB_OFS_RXDATA: rdata_nxt = {7'h00, rw_r.ninth, rw_r.data};
        `UNB_OFS_STATUS: rdata_nxt = {12'h000, irq_r, ovr_r, rvld_r, tbusy_r};
        default:         rdata_nxt = '0;
      endcase
    end
  end

  // transmitter
  always_comb begin
    ts_nxt    = ts_r;
    tt_nxt    = tt_r;
    tb_nxt    = tb_r;
    tw_nxt    = tw_r;
    tbusy_nxt = tbusy_r;
    tpar_nxt  = tpar_r;
    tir_nxt   = tir_r;
    txbit     = 1'b1;
    // data written while busy is dropped
    if (i_wr && i_addr == `UNB_OFS_TXDATA && !tbusy_r) begin
      tw_nxt    = '{data: i_wdata[7:0], ninth: i_wdata[8]};
      tbusy_nxt = 1'b1;
    end
    case (ts_r)
      UNB_IDLE: begin
        // RL13: latch format per char
        if (tbusy_r && tick) begin
          ts_nxt   = UNB_START;
          tt_nxt   = '0;
          tb_nxt   = '0;
          tpar_nxt = ctrl_r[`UNB_CTRL_PAR_EN];
          tir_nxt  = ctrl_r[`UNB_CTRL_IR_EN];
        end
      end
      UNB_START: txbit = 1'b0;
      UNB_DATA:  txbit = tw_r.data[tb_r];
      // RL1: ninth flag bit
      UNB_PAR:   txbit = tw_r.ninth;
      UNB_STOP:  txbit = 1'b1;
      default:   ts_nxt = UNB_IDLE;
    endcase
    if (ts_r != UNB_IDLE && tick) begin
      tt_nxt = tt_r + 1'b1;
      if (tt_r == 4'(`UNB_OVS - 1)) begin
        case (ts_r)
          UNB_START: ts_nxt = UNB_DATA;
          UNB_DATA: begin
            tb_nxt = tb_r + 1'b1;
            if (tb_r == 3'h7) ts_nxt = tpar_r ? UNB_PAR : UNB_STOP;
          end
          UNB_PAR:  ts_nxt = UNB_STOP;
          UNB_STOP: begin
            ts_nxt    = UNB_IDLE;
            tbusy_nxt = 1'b0;
          end
          default:  ts_nxt = UNB_IDLE;
        endcase
      end
    end
    tx_nxt = txbit;
    // RL6: 3/16 pulse
    // RL7: zero sent low
    if (tir_r && ts_r != UNB_IDLE)
      tx_nxt = txbit | (tt_r >= 4'(`UNB_IR_TX_TICKS));
  end

  // receiver; infrared pulses arrive high, so a seen pulse means zero
  always_comb begin
    line     = 1'b1;
    rs_nxt   = rs_r;
    rt_nxt   = rt_r;
    rb_nxt   = rb_r;
    rsh_nxt  = rsh_r;
    smp_nxt  = smp_r;
    rpar_nxt = rpar_r;
    rir_nxt  = rir_r;
    seen_nxt = seen_r;
    pw_nxt   = pw_r;
    rnin_nxt = rnin_r;
    rw_nxt   = rw_r;
    rvld_nxt = rvld_r;
    ovr_nxt  = ovr_r;
    if (i_rd && i_addr == `UNB_OFS_RXDATA) begin
      rvld_nxt = 1'b0;
      ovr_nxt  = 1'b0;
    end
    // RL13: format fixed per char
    if (rs_r == UNB_IDLE) begin
      rir_nxt  = ctrl_r[`UNB_CTRL_IR_EN];
      rpar_nxt = ctrl_r[`UNB_CTRL_PAR_EN];
    end
    if (tick) begin
      rt_nxt = rt_r + 1'b1;
      if (rir_r) begin
        // RL10: drop short glitch
        if (i_rx) pw_nxt = 1'b1;
        if (i_rx && pw_r) seen_nxt = 1'b1;
        if (!i_rx) pw_nxt = 1'b0;
      end else begin
        // RL9: three samples mid-bit
        if (rt_r >= 4'(`UNB_MID_TICK) && rt_r <= 4'(`UNB_MID_TICK + 2))
          smp_nxt = {smp_r[1:0], i_rx};
      end
      case (rs_r)
        UNB_IDLE: begin
          rt_nxt   = '0;
          seen_nxt = 1'b0;
          smp_nxt  = 3'b111;
          if ((ctrl_r[`UNB_CTRL_IR_EN] && i_rx) ||
              (!ctrl_r[`UNB_CTRL_IR_EN] && !i_rx)) begin
            rs_nxt = UNB_START;
            rt_nxt = 4'h1;
            pw_nxt = i_rx;
          end
        end
        default: begin
          if (rt_r == 4'(`UNB_OVS - 1)) begin
            // RL8: infrared input sampled at every tick
            // RL9: infrared bit is zero if a pulse high on two or more consecutive ticks was seen
            // decide before the bit's sample state is cleared
            line     = rir_r ? !seen_nxt : maj3(smp_nxt);
            rt_nxt   = '0;
            seen_nxt = 1'b0;
            smp_nxt  = 3'b111;
            case (rs_r)
              UNB_START: rs_nxt = line ? UNB_IDLE : UNB_DATA;
              UNB_DATA: begin
                rsh_nxt = {line, rsh_r[7:1]};
                rb_nxt  = rb_r + 1'b1;
                if (rb_r == 3'h7) rs_nxt = rpar_r ? UNB_PAR : UNB_STOP;
              end
              // flag held aside so the stored word stays whole
              UNB_PAR: begin
                rnin_nxt = line;
                rs_nxt   = UNB_STOP;
              end
              UNB_STOP: begin
                rs_nxt       = UNB_IDLE;
                rw_nxt.data  = rsh_r;
                rw_nxt.ninth = rpar_r & rnin_r;
                if (rvld_r && !(i_rd && i_addr == `UNB_OFS_RXDATA))
                  ovr_nxt = 1'b1;
                rvld_nxt = 1'b1;
              end
              default: rs_nxt = UNB_IDLE;
            endcase
          end
        end
      endcase
    end
    // RL3: ninth bit interrupt
    // RL4: receive register only
    irq_nxt = ctrl_r[`UNB_CTRL_PMASK] & rvld_nxt & rw_nxt.ninth;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_r  <= `UNB_CTRL_RST;
      baud_r  <= DIV_W'(`UNB_BAUD_RST);
      dcnt_r  <= '0;
      rdata_r <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      baud_r  <= baud_nxt;
      dcnt_r  <= dcnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ts_r    <= UNB_IDLE;
      tt_r    <= '0;
      tb_r    <= '0;
      tw_r    <= '0;
      tbusy_r <= 1'b0;
      tpar_r  <= 1'b0;
      tir_r   <= 1'b0;
      tx_r    <= 1'b1;
    end else begin
      ts_r    <= ts_nxt;
      tt_r    <= tt_nxt;
      tb_r    <= tb_nxt;
      tw_r    <= tw_nxt;
      tbusy_r <= tbusy_nxt;
      tpar_r  <= tpar_nxt;
      tir_r   <= tir_nxt;
      tx_r    <= tx_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rs_r   <= UNB_IDLE;
      rt_r   <= '0;
      rb_r   <= '0;
      rsh_r  <= '0;
      smp_r  <= 3'b111;
      rpar_r <= 1'b0;
      rir_r  <= 1'b0;
      seen_r <= 1'b0;
      pw_r   <= 1'b0;
      rnin_r <= 1'b0;
      rw_r   <= '0;
      rvld_r <= 1'b0;
      ovr_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      rs_r   <= rs_nxt;
      rt_r   <= rt_nxt;
      rb_r   <= rb_nxt;
      rsh_r  <= rsh_nxt;
      smp_r  <= smp_nxt;
      rpar_r <= rpar_nxt;
      rir_r  <= rir_nxt;
      seen_r <= seen_nxt;
      pw_r   <= pw_nxt;
      rnin_r <= rnin_nxt;
      rw_r   <= rw_nxt;
      rvld_r <= rvld_nxt;
      ovr_r  <= ovr_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_tx    = tx_r;
  assign o_irq   = irq_r;
endmodule // unb_uart

// *** tb/unb_uart_chk.sv ***
`include "unb_cfg.svh"
module unb_uart_chk #(parameter int DIV_W = 16) (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_tx,
  input wire logic        o_irq
);
  timeunit 1ns / 1ps;
  logic [2:0]  ctl_r, ctl_nxt;
  logic [15:0] bd_r, bd_nxt, low_r, low_nxt;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // shadow of mode, divisor and low-run length
  always_comb begin
    ctl_nxt = (i_wr && i_addr == `UNB_OFS_CTRL) ? i_wdata[2:0] : ctl_r;
    bd_nxt = (i_wr && i_addr == `UNB_OFS_BAUD) ? i_wdata : bd_r;
    low_nxt = o_tx ? 16'h0 : low_r + 16'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    ctl_r <= i_srst ? 3'h0 : ctl_nxt;
    bd_r <= i_srst ? `UNB_BAUD_RST : bd_nxt;
    low_r <= i_srst ? 16'h0 : low_nxt;
  end
  a_reset_idle: assert property (
    $fell(i_srst) |-> o_tx && !o_irq) else $error("not idle after reset");
  a_rdata_quiet: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0) else $error("data outside read");
  a_rdata_unmap: assert property (
    $past(i_rd && i_addr > 4'h4) |-> o_rdata == 16'h0) else $error("unmapped");
  a_irq_masked: assert property (
    !ctl_r[1] && !$past(ctl_r[1]) |-> !o_irq) else $error("irq masked");
  a_irq_cause: assert property (
    $rose(o_irq) |-> ctl_r[1:0] == 2'h3) else $error("irq without mode");
  a_irq_read: assert property (
    i_rd && i_addr == `UNB_OFS_RXDATA |-> ##[1:2] !o_irq) else $error("irq");
  a_ir_pulse: assert property (
    $rose(o_tx) && ctl_r[2] |-> low_r == 16'h3 * (bd_r + 16'h1))
    else $error("ir pulse width");
  a_bit_time: assert property (
    $rose(o_tx) && !ctl_r[2] |-> low_r % (16'h10 * (bd_r + 16'h1)) == 16'h0)
    else $error("bit time");
endmodule // unb_uart_chk
bind unb_uart unb_uart_chk #(.DIV_W(DIV_W)) u_chk (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_tx(o_tx), .o_irq(o_irq));

// *** tb/unb_line_model.sv ***
module unb_line_model (
  input  wire logic i_clk_sys,
  input  wire logic i_ir,
  input  wire logic i_loop,
  input  wire logic i_tx,
  output logic      o_rx
);
  timeunit 1ns / 1ps;
  logic drv_r = 1'b1;
  logic busy_r = 1'b0;
  assign o_rx = i_loop ? (i_ir ^ i_tx) : (busy_r ? drv_r : ~i_ir);
  task automatic send(input logic [8:0] w, input logic nine, input int pw);
    logic [10:0] f;
    f = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
    for (int i = 0; i < 176; i++) begin
      @(posedge i_clk_sys);
      busy_r <= 1'b1;
      drv_r <= i_ir ? (!f[i/16] && i % 16 < pw) : f[i/16];
    end
    @(posedge i_clk_sys);
    busy_r <= 1'b0;
  endtask
endmodule // unb_line_model

// *** tb/unb_uart_tb_top.sv ***
`include "unb_cfg.svh"
module unb_uart_tb_top;
  timeunit 1ns / 1ps;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        ir = 1'b0, loop = 1'b0, rx, tx, irq;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, d;
  int          errors = 0, tests_run = 0;
  unb_uart u_dut (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx(rx),
    .o_tx(tx), .o_irq(irq));
  unb_line_model u_line (.i_clk_sys(clk), .i_ir(ir), .i_loop(loop),
    .i_tx(tx), .o_rx(rx));
  initial forever #12.5 clk = ~clk;
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rx_chk(input logic [15:0] w, input logic q);
    d = 16'h0;
    for (int n = 0; n < 300 && d[1] !== 1'b1; n++)
      acc(1'b0, `UNB_OFS_STATUS, 16'h0);
    chk({15'h0, d[1]}, 16'h0001);
    if (d[1] !== 1'b1) conclude();
    chk({15'h0, irq}, {15'h0, q});
    acc(1'b0, `UNB_OFS_RXDATA, 16'h0);
    chk(d, w);
    @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    acc(1'b0, `UNB_OFS_CTRL, 16'h0);
    chk(d, 16'h0000);
    acc(1'b0, `UNB_OFS_BAUD, 16'h0);
    chk(d, `UNB_BAUD_RST);
    acc(1'b0, 4'hF, 16'h0);
    chk(d, 16'h0000);
    $display("test reset done");
    acc(1'b1, `UNB_OFS_BAUD, 16'h0);
    // no fifo, flag bit and mask on
    acc(1'b1, `UNB_OFS_CTRL, 16'h0003);
    u_line.send(9'h1A5, 1'b1, 3);
    rx_chk(16'h01A5, 1'b1);
    u_line.send(9'h05A, 1'b1, 3);
    rx_chk(16'h005A, 1'b0);
    u_line.send(9'h05A, 1'b1, 3);
    u_line.send(9'h1A5, 1'b1, 3);
    acc(1'b0, `UNB_OFS_STATUS, 16'h0);
    chk(d, 16'h000E);
    rx_chk(16'h01A5, 1'b1);
    acc(1'b1, `UNB_OFS_CTRL, 16'h0001);
    u_line.send(9'h1A5, 1'b1, 3);
    rx_chk(16'h01A5, 1'b0);
    $display("test ninth bit done");
    loop <= 1'b1;
    acc(1'b1, `UNB_OFS_CTRL, 16'h0003);
    acc(1'b1, `UNB_OFS_TXDATA, 16'h0155);
    acc(1'b0, `UNB_OFS_STATUS, 16'h0);
    chk({15'h0, d[0]}, 16'h0001);
    acc(1'b1, `UNB_OFS_TXDATA, 16'h00AA);
    rx_chk(16'h0155, 1'b1);
    acc(1'b1, `UNB_OFS_CTRL, 16'h0004);
    ir <= 1'b1;
    acc(1'b1, `UNB_OFS_TXDATA, 16'h00C3);
    rx_chk(16'h00C3, 1'b0);
    $display("test loopback done");
    loop <= 1'b0;
    u_line.send(9'h000, 1'b0, 1);
    repeat (32) @(posedge clk);
    acc(1'b0, `UNB_OFS_STATUS, 16'h0);
    chk(d, 16'h0000);
    u_line.send(9'h03C, 1'b0, 3);
    rx_chk(16'h003C, 1'b0);
    $display("test infrared done");
    conclude();
  end
endmodule // unb_uart_tb_top
